// ---- lp_dram_mode_register_bank.v ----
// Notes on behaviour
// - Burst code must be eight; default eight.
// - Burst order wraps modulo eight, C0 zero.
// - Recovery code plus extend bit give cycles.
// - Recovery count delays precharge after writes.
// - Set A maps latency codes to RL/WL.
// - Set B gives longer write latencies for codes 8h and up.
// - Bit seven enables write leveling.
// - Refresh-rate field reports temperature band.
// - Temperature read clears flag; zero at reset.
// - Flag sets when rate changed since read.
// - Rate bit two means above 85C.
// - Address 05h returns maker code.
// - Address 08h returns type, density, width.
// - Calibration codes start calibration operations.
// - Reserved calibration codes are ignored.
// - Strapped pin forces default calibration.
// - Termination bits select data termination.
// - Bit two keeps termination in power-down.
// - Bank mask blocks self-refresh per bank.
// - Segment mask blocks rows by R[14:12].
// - Write to 3Fh resets the device.
// - Read and write commands use 8-bit address.
// - Unused bits read back as zero.
// - Write-only reads undefined; read-only writes ignored.
`timescale 1ns/100ps
`include "mrb_defs.vh"

module lp_dram_mode_register_bank #(
	parameter [7:0] MAKER_ID = 8'h5a,   // Arbitrary neutral value.
	parameter [7:0] REV_ONE  = 8'h11,   // Arbitrary neutral value.
	parameter [7:0] REV_TWO  = 8'h22    // Arbitrary neutral value.
) (
	input  wire       mclk_i,             // Device clock.
	input  wire       arst_n_i,           // Asynchronous reset, active low.
	input  wire       mrw_i,              // Mode register write command.
	input  wire       mrr_i,              // Mode register read command.
	input  wire [7:0] addr_i,             // Register address.
	input  wire [7:0] wdata_i,            // Write data.
	input  wire [2:0] rate_i,             // Refresh rate from the sensor.
	input  wire       cal_strap_i,        // Calibration pin strapped to supply.
	input  wire [2:0] burst_start_i,      // Column bits C2..C0 of a burst.
	input  wire       burst_load_i,       // Start a burst address sequence.
	output reg  [7:0] rdata_o,            // Read data.
	output reg        rvalid_o,           // Read data valid pulse.
	output reg  [2:0] burst_col_o,        // Current burst column.
	output reg  [4:0] wr_recovery_o,      // Write recovery cycles.
	output reg        wr_recovery_ok_o,   // Recovery code is defined.
	output reg  [4:0] read_latency_o,     // Read latency in cycles.
	output reg  [4:0] write_latency_o,    // Write latency in cycles.
	output reg        latency_ok_o,       // Latency code is defined.
	output reg        wr_level_en_o,      // Write leveling enabled.
	output reg  [3:0] drive_strength_o,   // Drive strength select.
	output reg  [1:0] data_term_o,        // Data termination select.
	output reg        term_in_pd_o,       // Termination kept in power-down.
	output reg  [7:0] bank_mask_o,        // Self-refresh bank mask.
	output reg  [7:0] seg_mask_o,         // Self-refresh segment mask.
	output reg        cal_init_o,         // Initial calibration start pulse.
	output reg        cal_long_o,         // Long calibration start pulse.
	output reg        cal_short_o,        // Short calibration start pulse.
	output reg        cal_reset_o,        // Calibration reset pulse.
	output reg        soft_reset_o,       // Device reset pulse.
	output reg        over_85c_o,         // Die above 85 degrees.
	output reg        temp_limit_o,       // Outside operating temperature.
	output reg        derate_o            // Timing derating required.
);

	// ======================================================================
	// Burst sequencer states, one-hot.
	localparam [1:0] ST_IDLE  = 2'b01;
	localparam [1:0] ST_BURST = 2'b10;

	// ======================================================================
	// Stored fields and internal nets.
	// The vendor test byte is kept only so a write has somewhere to land.

	reg  [7:0] burst_wr_r;
	reg  [7:0] latency_r;
	reg  [7:0] io_drive_r;
	reg  [7:0] term_r;
	reg  [7:0] test_mode_r;
	reg  [2:0] rate_r;
	reg        tuf_r;
	reg  [1:0] state_r;
	reg  [2:0] beat_r;
	reg  [2:0] col_base_r;
	reg  [10:0] lat_nxt;
	wire [4:0] rec_cycles;
	wire       rec_valid;
	wire       wr_cmd;
	wire       rd_temp;

	// ======================================================================
	// Latency decode.
	// Both latency sets share read-latency codes; only write latency moves.
	function [10:0] lat_decode;
		input [3:0] code;
		input       set_b;
		begin
			lat_decode = 11'h000;
			case (code)
				4'h1: lat_decode = {1'b1, 5'd3, 5'd1};
				4'h6: lat_decode = {1'b1, 5'd8, 5'd4};
				4'h7: lat_decode = {1'b1, 5'd9, 5'd5};
				4'h8: lat_decode = {1'b1, 5'd10, set_b ? 5'd8 : 5'd6};
				4'h9: lat_decode = {1'b1, 5'd11, set_b ? 5'd9 : 5'd6};
				4'ha: lat_decode = {1'b1, 5'd12, set_b ? 5'd9 : 5'd6};
				4'hc: lat_decode = {1'b1, 5'd14, set_b ? 5'd11 : 5'd8};
				4'he: lat_decode = {1'b1, 5'd16, set_b ? 5'd13 : 5'd8};
				default: lat_decode = 11'h000;
			endcase
		end
	endfunction

	// ======================================================================
	// Calibration code match.
	// One compare shared by the three start pulses and the reset pulse keeps the decode in one place.
	function cal_hit;
		input [7:0] addr;
		input [7:0] data;
		input [7:0] code;
		begin
			cal_hit = (addr == `ADDR_CAL_CMD) && (data == code);
		end
	endfunction

	// ======================================================================
	// Command qualification.
	// A write collides with a read in the same cycle only by controller fault;
	// the write is taken and the read still answers.
	assign wr_cmd  = mrw_i;
	assign rd_temp = mrr_i && (addr_i == `ADDR_TEMP_STATUS);

	wr_recovery_decode u_wr_dec (
		.code_i   (burst_wr_r[7:5]),
		.extend_i (latency_r[4]),
		.cycles_o (rec_cycles),
		.valid_o  (rec_valid)
	);

	// ======================================================================
	// Configuration registers.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			burst_wr_r  <= `RST_BURST_WR;
			latency_r   <= `RST_LATENCY_LEV;
			io_drive_r  <= `RST_IO_DRIVE;
			term_r      <= `RST_TERM_CTRL;
			test_mode_r <= 8'h00;
			bank_mask_o <= `RST_MASK;
			seg_mask_o  <= `RST_MASK;
		end else if (wr_cmd && (addr_i == `ADDR_SOFT_RESET)) begin
			burst_wr_r  <= `RST_BURST_WR;
			latency_r   <= `RST_LATENCY_LEV;
			io_drive_r  <= `RST_IO_DRIVE;
			term_r      <= `RST_TERM_CTRL;
			test_mode_r <= 8'h00;
			bank_mask_o <= `RST_MASK;
			seg_mask_o  <= `RST_MASK;
		end else if (wr_cmd) begin
			case (addr_i)
				`ADDR_BURST_WR:    burst_wr_r <= {wdata_i[7:5], 2'b00, `BURST_LEN_EIGHT};
				`ADDR_LATENCY_LEV: latency_r <= {wdata_i[7:6], 1'b0, wdata_i[4:0]};
				`ADDR_IO_DRIVE:    io_drive_r <= {4'h0, wdata_i[3:0]};
				`ADDR_TERM_CTRL:   term_r <= {5'h00, wdata_i[2:0]};
				`ADDR_TEST_MODE:   test_mode_r <= wdata_i;
				`ADDR_BANK_MASK:   bank_mask_o <= wdata_i;
				`ADDR_SEG_MASK:    seg_mask_o <= wdata_i;
				default:           test_mode_r <= test_mode_r;
			endcase
		end
	end

	// ======================================================================
	// Temperature tracking.
	// The set wins over a read clear so a change during the read is kept.
	// The change is judged against the last sampled rate, so the flag and the
	// read-back field move one cycle after the sensor input.
	// A limitation: a change that reverts within one cycle is still flagged.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rate_r <= `RATE_RESET;
			tuf_r  <= 1'b0;
		end else begin
			rate_r <= rate_i;
			if (rate_i != rate_r)
				tuf_r <= 1'b1;
			else if (rd_temp)
				tuf_r <= 1'b0;
		end
	end

	// ======================================================================
	// Read path, one cycle after the command.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o  <= 8'h00;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= mrr_i;
			if (mrr_i) begin
				case (addr_i)
					`ADDR_TEMP_STATUS: rdata_o <= {tuf_r, 4'h0, rate_r};
					`ADDR_MAKER_ID:    rdata_o <= MAKER_ID;
					`ADDR_REV_ONE:     rdata_o <= REV_ONE;
					`ADDR_REV_TWO:     rdata_o <= REV_TWO;
					`ADDR_GEOMETRY:    rdata_o <= {`WIDTH_CODE, `DENSITY_CODE, `MEM_TYPE_CODE};
					default:           rdata_o <= `UNDEF_READ_DATA;
				endcase
			end
		end
	end

	// ======================================================================
	// Calibration and reset command pulses.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cal_init_o   <= 1'b0;
			cal_long_o   <= 1'b0;
			cal_short_o  <= 1'b0;
			cal_reset_o  <= 1'b0;
			soft_reset_o <= 1'b0;
		end else begin
			soft_reset_o <= wr_cmd && (addr_i == `ADDR_SOFT_RESET);

			// reserved codes ignored
			// Any code not matched below gives no pulse at all.
			cal_init_o  <= wr_cmd && cal_hit(addr_i, wdata_i, `CAL_INIT) && !cal_strap_i;
			cal_long_o  <= wr_cmd && cal_hit(addr_i, wdata_i, `CAL_LONG) && !cal_strap_i;
			cal_short_o <= wr_cmd && cal_hit(addr_i, wdata_i, `CAL_SHORT) && !cal_strap_i;

			// A strapped pin still allows a return to default calibration.
			cal_reset_o <= wr_cmd && cal_hit(addr_i, wdata_i, `CAL_RESET);
		end
	end

	// ======================================================================
	// Decoded configuration outputs, registered so they come from flops.
	// The top bit of the decode marks a defined code; the rest are the latencies.
	always @* begin
		lat_nxt = lat_decode(latency_r[3:0], latency_r[6]);
	end

	// Every decoded field is registered so the outputs come straight from flops,
	// at the cost of one extra cycle after a configuration write.

	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_recovery_o    <= 5'h00;
			wr_recovery_ok_o <= 1'b0;
			read_latency_o   <= 5'h00;
			write_latency_o  <= 5'h00;
			latency_ok_o     <= 1'b0;
			wr_level_en_o    <= 1'b0;
			drive_strength_o <= 4'h0;
			data_term_o      <= 2'h0;
			term_in_pd_o     <= 1'b0;
			over_85c_o       <= 1'b0;
			temp_limit_o     <= 1'b0;
			derate_o         <= 1'b0;
		end else begin
			wr_recovery_o    <= rec_cycles;
			wr_recovery_ok_o <= rec_valid;
			read_latency_o   <= lat_nxt[9:5];
			write_latency_o  <= lat_nxt[4:0];
			latency_ok_o     <= lat_nxt[10];

			wr_level_en_o    <= latency_r[7];
			drive_strength_o <= io_drive_r[3:0];

			data_term_o      <= term_r[1:0];
			term_in_pd_o     <= term_r[2];

			// Temperature indications follow the sampled rate, not the raw input.
			// hot indication
			over_85c_o       <= rate_r[2];
			temp_limit_o     <= (rate_r == 3'h0) || (rate_r == 3'h7);
			derate_o         <= (rate_r == 3'h6);
		end
	end

	// ======================================================================
	// Burst column sequencer; C0 is forced to zero and the count wraps at eight.
	// Loads seen while a burst runs are ignored, since bursts cannot be cut.
	// The three-bit sum wraps by itself, so no modulo logic is needed.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r     <= ST_IDLE;
			beat_r      <= 3'h0;
			col_base_r  <= 3'h0;
			burst_col_o <= 3'h0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (burst_load_i) begin
						col_base_r  <= {burst_start_i[2:1], 1'b0};
						burst_col_o <= {burst_start_i[2:1], 1'b0};
						beat_r      <= 3'h1;
						state_r     <= ST_BURST;
					end
				end
				ST_BURST: begin
					burst_col_o <= col_base_r + beat_r;
					beat_r      <= beat_r + 3'h1;
					if (beat_r == 3'h7)
						state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

endmodule

// ---- mrb_defs.vh ----
`ifndef MRB_DEFS_VH
`define MRB_DEFS_VH

// ==========================================================================
// Register addresses.
`define ADDR_BURST_WR       8'h01
`define ADDR_LATENCY_LEV    8'h02
`define ADDR_IO_DRIVE       8'h03
`define ADDR_TEMP_STATUS    8'h04
`define ADDR_MAKER_ID       8'h05
`define ADDR_REV_ONE        8'h06
`define ADDR_REV_TWO        8'h07
`define ADDR_GEOMETRY       8'h08
`define ADDR_TEST_MODE      8'h09
`define ADDR_CAL_CMD        8'h0a
`define ADDR_TERM_CTRL      8'h0b
`define ADDR_BANK_MASK      8'h10
`define ADDR_SEG_MASK       8'h11
`define ADDR_SOFT_RESET     8'h3f

// ==========================================================================
// Reset values of the write-only configuration registers.
`define RST_BURST_WR        8'h03
`define RST_LATENCY_LEV     8'h18
`define RST_IO_DRIVE        8'h02
`define RST_TERM_CTRL       8'h00
`define RST_MASK            8'h00

// ==========================================================================
// Field codes.
`define BURST_LEN_EIGHT     3'h3
`define SOFT_RESET_DATA     8'hfc
`define CAL_INIT            8'hff
`define CAL_LONG            8'hab
`define CAL_SHORT           8'h56
`define CAL_RESET           8'hc3
`define MEM_TYPE_CODE       2'h3
`define DENSITY_CODE        4'h7
`define WIDTH_CODE          2'h0
`define RATE_RESET          3'h3

// ==========================================================================
// Read-back data used for write-only or unused addresses.
`define UNDEF_READ_DATA     8'h00

`endif

// ---- wr_recovery_decode.v ----
`timescale 1ns/100ps

// ==========================================================================
// Decoder from the write-recovery code and extend bit to a cycle count.
module wr_recovery_decode (
	input  wire [2:0] code_i,     // Write-recovery code field.
	input  wire       extend_i,   // Extend bit selecting the upper range.
	output reg  [4:0] cycles_o,   // Decoded cycle count, zero when reserved.
	output reg        valid_o     // High when the code is defined.
);

	always @* begin
		cycles_o = 5'h00;
		valid_o  = 1'b1;
		case ({extend_i, code_i})
			4'h1: cycles_o = 5'h03;
			4'h4: cycles_o = 5'h06;
			4'h6: cycles_o = 5'h08;
			4'h7: cycles_o = 5'h09;
			4'h8: cycles_o = 5'h0a;
			4'h9: cycles_o = 5'h0b;
			4'ha: cycles_o = 5'h0c;
			4'hc: cycles_o = 5'h0e;
			4'he: cycles_o = 5'h10;
			default: valid_o = 1'b0;
		endcase
	end

endmodule

// ---- mrb_chk.sv ----
`timescale 1ns/100ps
// ==========
// Port checks of the mode register bank.
module mrb_chk (
	input logic       mclk_i,
	input logic       arst_n_i,
	input logic       mrw_i,
	input logic       mrr_i,
	input logic [7:0] addr_i,
	input logic [7:0] wdata_i,
	input logic       cal_strap_i,
	input logic [2:0] burst_start_i,
	input logic       burst_load_i,
	input logic [7:0] rdata_o,
	input logic       rvalid_o,
	input logic [2:0] burst_col_o,
	input logic [7:0] bank_mask_o,
	input logic       cal_init_o,
	input logic       cal_long_o,
	input logic       cal_short_o,
	input logic       cal_reset_o,
	input logic       soft_reset_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	// Decode of a calibration write and of any start pulse.
	wire is_cal = mrw_i && addr_i == 8'h0a;
	wire cal_ok = wdata_i == 8'hff || wdata_i == 8'hab || wdata_i == 8'h56 || wdata_i == 8'hc3;
	wire any_go = cal_init_o | cal_long_o | cal_short_o;
	// The burst walk is a first column then seven wrapping steps.
	sequence s_first;
		burst_col_o == {$past(burst_start_i[2:1]), 1'b0};
	endsequence
	sequence s_step;
		burst_col_o == $past(burst_col_o) + 3'h1;
	endsequence
	chk_read_answer: assert property (mrr_i |=> rvalid_o) else $error("read not answered");
	chk_valid_cause: assert property (!mrr_i |=> !rvalid_o) else $error("stray read valid");
	chk_cal_long: assert property (is_cal && wdata_i == 8'hab && !cal_strap_i |=> cal_long_o && !cal_init_o)
		else $error("long calibration not started");
	chk_cal_ignore: assert property (!(is_cal && cal_ok) |=> !any_go && !cal_reset_o) else $error("stray cal pulse");
	chk_strap_block: assert property (cal_strap_i |=> !any_go) else $error("strap did not block");
	chk_soft_reset: assert property (mrw_i && addr_i == 8'h3f |=> soft_reset_o) else $error("no reset pulse");
	chk_bank_store: assert property (mrw_i && addr_i == 8'h10 |=> bank_mask_o == $past(wdata_i))
		else $error("bank mask not stored");
	chk_temp_rfu: assert property (rvalid_o && $past(addr_i) == 8'h04 |-> rdata_o[6:3] == 4'h0)
		else $error("unused bits set");
	chk_burst_walk: assert property (burst_load_i |=> s_first ##1 s_step [*7]) else $error("burst order");
endmodule

// ---- mrb_ctrl_model.sv ----
`timescale 1ns/100ps
// ==========
// Controller model issuing mode register commands.
module mrb_ctrl_model (
	input  logic       mclk_i,   // Device clock.
	input  logic [7:0] rdata_i,  // Read data.
	output logic       mrw_o,    // Write command.
	output logic       mrr_o,    // Read command.
	output logic [7:0] addr_o,   // Register address.
	output logic [7:0] wdata_o   // Write data.
);
	// Idle bus at time zero.
	initial begin
		mrw_o = 1'b0;
		mrr_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// one-byte write command
	// Lines are inverted when released so stale values never look valid.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		{mrw_o, addr_o, wdata_o} = {1'b1, a, d};
		@(negedge mclk_i);
		{mrw_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk_i);
		{mrr_o, addr_o} = {1'b1, a};
		@(negedge mclk_i);
		{mrr_o, addr_o} = {1'b0, ~a};
		d = rdata_i;
	endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
	logic mclk_i = 0, arst_n_i = 0, cal_strap_i = 0, burst_load_i = 0;
	logic mrw_i, mrr_i, rvalid_o, wr_recovery_ok_o, latency_ok_o, wr_level_en_o, term_in_pd_o;
	logic cal_init_o, cal_long_o, cal_short_o, cal_reset_o, soft_reset_o, over_85c_o, temp_limit_o, derate_o;
	logic [2:0] rate_i = 3'h3, burst_start_i = 3'h0, burst_col_o;
	logic [7:0] addr_i, wdata_i, rdata_o, bank_mask_o, seg_mask_o, v;
	logic [4:0] wr_recovery_o, read_latency_o, write_latency_o;
	logic [3:0] drive_strength_o;
	logic [1:0] data_term_o;
	int fail_count = 0, tests_run = 0;
	logic [7:0] lc [8] = '{8'h01, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0c, 8'h0e};
	logic [7:0] rl [8] = '{8'h03, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0e, 8'h10};
	logic [7:0] wa [8] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h06, 8'h06, 8'h08, 8'h08};
	logic [7:0] wb [8] = '{8'h01, 8'h04, 8'h05, 8'h08, 8'h09, 8'h09, 8'h0b, 8'h0d};
	// Entries are extend bit and code, then the cycle count.
	logic [11:0] wt [10] = '{12'h103, 12'h406, 12'h608, 12'h709, 12'h80a, 12'h90b, 12'ha0c, 12'hc0e, 12'he10, 12'h000};
	logic [15:0] it [5] = '{16'h055a, 16'h0611, 16'h0722, 16'h081f, 16'h0100};
	logic [7:0] cc [5] = '{8'hff, 8'hab, 8'h56, 8'hc3, 8'h12};

	always #50 mclk_i = ~mclk_i;
	lp_dram_mode_register_bank lp_dram_mode_register_bank_inst (.*);
	mrb_ctrl_model mrb_ctrl_model_inst (.mclk_i, .rdata_i(rdata_o), .mrw_o(mrw_i), .mrr_o(mrr_i), .addr_o(addr_i),
		.wdata_o(wdata_i));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("checks=%0d mismatches=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic do_reset(input logic s);
		arst_n_i = 1'b0;
		cal_strap_i = s;
		repeat (12) @(negedge mclk_i);
		arst_n_i = 1'b1;
		repeat (2) @(negedge mclk_i);
	endtask

	// A hang is cut short well past the expected run length.
	initial begin
		#400000;
		fail_count++;
		summarize;
	end

	// Main sequence; callers write unused bits as 0 and never read 3Fh.
	initial begin
		do_reset(1'b0);
		chk(wr_recovery_o, 8'h0a);
		chk({read_latency_o, 3'h0}, {5'h0a, 3'h0});
		chk(write_latency_o, 8'h06);
		chk({wr_level_en_o, data_term_o, term_in_pd_o, bank_mask_o | seg_mask_o}, 8'h00);
		chk(drive_strength_o, 8'h02);
		for (int i = 0; i < 10; i++) begin
			mrb_ctrl_model_inst.wr(8'h02, {3'h0, wt[i][11], 4'h8});
			mrb_ctrl_model_inst.wr(8'h01, {wt[i][10:8], 5'h03});
			@(negedge mclk_i);
			chk(wr_recovery_o, wt[i][7:0]);
			chk(wr_recovery_ok_o, wt[i][7:0] != 8'h00);
		end
		for (int i = 0; i < 16; i++) begin
			mrb_ctrl_model_inst.wr(8'h02, {i[0], i[3], 2'h1, lc[i % 8][3:0]});
			@(negedge mclk_i);
			chk(read_latency_o, rl[i % 8]);
			chk(write_latency_o, i[3] ? wb[i % 8] : wa[i % 8]);
			chk({latency_ok_o, wr_level_en_o}, {1'b1, i[0]});
		end
		mrb_ctrl_model_inst.wr(8'h02, 8'h12);
		@(negedge mclk_i);
		chk(latency_ok_o, 8'h00);
		mrb_ctrl_model_inst.rd(8'h04, v);
		chk(v, 8'h03);
		for (int r = 0; r < 8; r++) begin
			rate_i = r[2:0];
			repeat (3) @(negedge mclk_i);
			chk({over_85c_o, temp_limit_o}, {r[2], r == 0 || r == 7});
			chk(derate_o, r == 6);
			mrb_ctrl_model_inst.rd(8'h04, v);
			chk(v, {5'h10, r[2:0]});
			mrb_ctrl_model_inst.rd(8'h04, v);
			chk(v, {5'h00, r[2:0]});
		end
		mrb_ctrl_model_inst.wr(8'h05, 8'h00);
		mrb_ctrl_model_inst.wr(8'h08, 8'h00);
		for (int i = 0; i < 5; i++) begin
			mrb_ctrl_model_inst.rd(it[i][15:8], v);
			chk(v, it[i][7:0]);
		end
		mrb_ctrl_model_inst.wr(8'h10, 8'ha5);
		mrb_ctrl_model_inst.wr(8'h11, 8'h3c);
		mrb_ctrl_model_inst.wr(8'h03, 8'h03);
		mrb_ctrl_model_inst.wr(8'h0b, 8'h06);
		mrb_ctrl_model_inst.wr(8'h09, 8'hff);
		@(negedge mclk_i);
		chk({bank_mask_o, seg_mask_o}, 16'ha53c);
		chk({drive_strength_o, 1'b0, term_in_pd_o, data_term_o}, 8'h36);
		mrb_ctrl_model_inst.wr(8'h3f, 8'hfc);
		chk(soft_reset_o, 8'h01);
		@(negedge mclk_i);
		chk(bank_mask_o | seg_mask_o, 8'h00);
		for (int b = 2; b < 8; b += 3) begin
			burst_start_i = b[2:0];
			burst_load_i = 1'b1;
			@(negedge mclk_i);
			burst_load_i = 1'b0;
			for (int k = 0; k < 8; k++) begin
				chk(burst_col_o, ((b & 6) + k) & 7);
				@(negedge mclk_i);
			end
		end
		for (int s = 0; s < 2; s++) begin
			do_reset(s[0]);
			for (int i = 0; i < 5; i++) begin
				mrb_ctrl_model_inst.wr(8'h0a, cc[i]);
				chk({cal_init_o, cal_long_o, cal_short_o, cal_reset_o},
					(i < 4 && !(s == 1 && i < 3)) ? 8'h08 >> i : 8'h00);
			end
		end
		summarize;
	end
endmodule
bind lp_dram_mode_register_bank mrb_chk mrb_chk_inst (.*);
